// ==== hdl/flash_seq_params.svh ====
// constants of the flash command sequencer: codes, addresses, timing
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ---------------------------------------------------------------
// command enable field codes
// ---------------------------------------------------------------
`define CMD_FIELD_ENABLE   4'h3
`define CMD_FIELD_DISABLE  4'hC

// ---------------------------------------------------------------
// command sequence addresses and data
// ---------------------------------------------------------------
`define UNLOCK_ADDR_1      16'hF555
`define UNLOCK_ADDR_2      16'hFAAA
`define UNLOCK_DATA_1      8'hAA
`define UNLOCK_DATA_2      8'h55
`define ERASE_SETUP_DATA   8'h80
`define SECTOR_ERASE_DATA  8'h30
`define BYTE_PROG_DATA     8'hA0

// ---------------------------------------------------------------
// memory map
// ---------------------------------------------------------------
`define FLASH_SEL_BIT      15
`define SECTOR_MSB         14
`define SECTOR_LSB         12
`define ERASED_BYTE        8'hFF
`define ROM_BASE_TAG       5'h0F
`define ROM_ADDR_MSB       10
`define STATUS_TOGGLE_BIT  6
`define STATUS_IDLE_BITS   8'h00
`define UNMAPPED_READ      8'h00

// ---------------------------------------------------------------
// timing, clock period 25 ns
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define PROG_TIME_NS       40000
`define PROG_CYCLES        ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECTOR_LAST        12'hFFF
`define STRAP_SETTLE       2'h2

`endif

// ==== hdl/flash_seq_pkg.sv ====
// types shared by the flash command sequencer files
package flash_seq_pkg;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_UNLK1  = 3'b001,
		S_UNLK2  = 3'b010,
		S_PROG   = 3'b011,
		S_ERASE3 = 3'b100,
		S_ERASE4 = 3'b101,
		S_ERASE5 = 3'b110,
		S_BUSY   = 3'b111
	} seq_state_t;

	typedef enum logic [2:0] {
		LM_FLASH_WRITE = 3'b000,
		LM_RAM_LOADER  = 3'b001,
		LM_CHECKSUM    = 3'b010,
		LM_PRODUCT_ID  = 3'b011,
		LM_STATUS      = 3'b100,
		LM_ERASE       = 3'b101,
		LM_READ_PROT   = 3'b110
	} loader_mode_t;

endpackage

// ==== hdl/flash_array.sv ====
// flash byte array with timed byte program and sector erase walk
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_array (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        prog_go,
	input  wire logic        erase_go,
	input  wire logic [14:0] op_addr,
	input  wire logic [7:0]  op_data,
	input  wire logic [14:0] rd_addr,
	output logic      [7:0]  rd_data,
	output logic             busy
);
	logic [7:0]  mem [0:32767] = '{default: `ERASED_BYTE};
	logic        busy_r,  busy_nxt;
	logic        erase_r, erase_nxt;
	logic [11:0] cnt_r,   cnt_nxt;
	logic [14:0] addr_r,  addr_nxt;

	assign rd_data = mem[rd_addr];
	assign busy    = busy_r;

	// ---------------------------------------------------------------
	// operation timer
	// ---------------------------------------------------------------
	always_comb begin
		busy_nxt  = busy_r;
		erase_nxt = erase_r;
		cnt_nxt   = cnt_r;
		addr_nxt  = addr_r;
		if (prog_go) begin
			busy_nxt  = 1'b1;
			erase_nxt = 1'b0;
			cnt_nxt   = 12'(`PROG_CYCLES - 1);
		end else if (erase_go) begin
			busy_nxt  = 1'b1;
			erase_nxt = 1'b1;
			cnt_nxt   = `SECTOR_LAST;
			addr_nxt  = {op_addr[`SECTOR_MSB:`SECTOR_LSB], 12'h000};
		end else if (busy_r) begin
			cnt_nxt  = cnt_r - 12'h001;
			addr_nxt = addr_r + 15'h0001;
			if (cnt_r == 12'h000) begin
				busy_nxt  = 1'b0;
				erase_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r  <= 1'b0;
			erase_r <= 1'b0;
			cnt_r   <= 12'h000;
			addr_r  <= 15'h0000;
		end else begin
			busy_r  <= busy_nxt;
			erase_r <= erase_nxt;
			cnt_r   <= cnt_nxt;
			addr_r  <= addr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// array writes
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (prog_go) begin
			mem[op_addr] <= mem[op_addr] & op_data;
		end else if (busy_r && erase_r) begin
			mem[addr_r] <= `ERASED_BYTE;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	erase_in_sector_a: assert property (
		(busy_r && erase_r && !erase_go)
		|=> addr_r[`SECTOR_MSB:`SECTOR_LSB] == $past(addr_r[`SECTOR_MSB:`SECTOR_LSB])
		    || $past(cnt_r) == 12'h000
	) else $error("erase walk left its sector");
endmodule

// ==== hdl/loader_rom.sv ====
// 2048-byte loader rom: mode dispatch table, rest reads erased
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module loader_rom (
	input  wire logic [10:0] rd_addr,
	output logic      [7:0]  rd_data
);
	import flash_seq_pkg::*;

	function automatic logic [7:0] rom_byte(input logic [10:0] a);
		case (a)
			11'h000: rom_byte = {5'h00, LM_FLASH_WRITE};
			11'h001: rom_byte = {5'h00, LM_RAM_LOADER};
			11'h002: rom_byte = {5'h00, LM_CHECKSUM};
			11'h003: rom_byte = {5'h00, LM_PRODUCT_ID};
			11'h004: rom_byte = {5'h00, LM_STATUS};
			11'h005: rom_byte = {5'h00, LM_ERASE};
			11'h006: rom_byte = {5'h00, LM_READ_PROT};
			default: rom_byte = `ERASED_BYTE;
		endcase
	endfunction

	assign rd_data = rom_byte(rd_addr);
endmodule

// ==== hdl/flash_cmd_sequencer.sv ====
// flash command sequencer: enable gate, unlock sequences, polling, loader rom
`timescale 1ns/1ps
`include "flash_seq_params.svh"

// Summary of operation
// - field 0011 enables command sequences
// - field 1100 blocks sequences, read mode
// - sector erase: six writes, sector address last
// - byte program: four writes, data last
// - erase clears whole 4-kbyte sector
// - busy reads differ until done
// - bit 6 toggles, first read one
// - busy reads return status, no vectors
// - idle read returns stored byte
// - serial mode maps rom 7800-7FFF
// - serial mode from select pins, reset
// - loader rom offers seven modes

module flash_cmd_sequencer (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [3:0]                command_enable_field,
	input  wire logic                      factory_sel_pin,
	input  wire logic                      loader_sel_pin,
	input  wire logic [15:0]               bus_addr,
	input  wire logic [7:0]                bus_wdata,
	input  wire logic                      bus_wr,
	input  wire logic                      bus_rd,
	output logic      [7:0]                rd_data_r,
	output logic                           rd_valid_r,
	output logic                           op_busy_r,
	output logic                           cmd_enabled_r,
	output logic                           serial_mode_r,
	output flash_seq_pkg::seq_state_t      state_r
);
	import flash_seq_pkg::*;

	seq_state_t  state_nxt;
	logic        cmd_enabled_nxt;
	logic        prog_go_r,  prog_go_nxt;
	logic        erase_go_r, erase_go_nxt;
	logic [14:0] op_addr_r,  op_addr_nxt;
	logic [7:0]  op_data_r,  op_data_nxt;
	logic        toggle_r,   toggle_nxt;
	logic        op_busy_nxt;
	logic [7:0]  rd_data_nxt;
	logic        rd_valid_nxt;
	logic [1:0]  pin_meta_r;
	logic [1:0]  pin_sync_r;
	logic [1:0]  strap_cnt_r, strap_cnt_nxt;
	logic        serial_mode_nxt;
	logic        arr_busy;
	logic [7:0]  arr_rdata;
	logic [7:0]  rom_rdata;
	logic        flash_hit;
	logic        rom_hit;
	logic        wr_ok;

	assign flash_hit = bus_addr[`FLASH_SEL_BIT];
	assign rom_hit   = serial_mode_r && (bus_addr[15:11] == `ROM_BASE_TAG);
	assign wr_ok     = bus_wr && flash_hit && cmd_enabled_r && (state_r != S_BUSY);

	flash_array u_array (
		.clk      (clk),
		.rst_n    (rst_n),
		.prog_go  (prog_go_r),
		.erase_go (erase_go_r),
		.op_addr  (op_addr_r),
		.op_data  (op_data_r),
		.rd_addr  (bus_addr[14:0]),
		.rd_data  (arr_rdata),
		.busy     (arr_busy)
	);

	loader_rom u_rom (
		.rd_addr (bus_addr[`ROM_ADDR_MSB:0]),
		.rd_data (rom_rdata)
	);

	// ---------------------------------------------------------------
	// command enable gate
	// ---------------------------------------------------------------
	always_comb begin
		cmd_enabled_nxt = cmd_enabled_r;
		if (command_enable_field == `CMD_FIELD_ENABLE) begin
			cmd_enabled_nxt = 1'b1;
		end else if (command_enable_field == `CMD_FIELD_DISABLE) begin
			cmd_enabled_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_enabled_r <= 1'b0;
		end else begin
			cmd_enabled_r <= cmd_enabled_nxt;
		end
	end

	// ---------------------------------------------------------------
	// command sequence decoder
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		prog_go_nxt  = 1'b0;
		erase_go_nxt = 1'b0;
		op_addr_nxt  = op_addr_r;
		op_data_nxt  = op_data_r;
		op_busy_nxt  = op_busy_r;
		toggle_nxt   = toggle_r;
		if (state_r == S_BUSY) begin
			if (!prog_go_r && !erase_go_r && !arr_busy) begin
				state_nxt   = S_IDLE;
				op_busy_nxt = 1'b0;
			end
		end else if (!cmd_enabled_r) begin
			state_nxt = S_IDLE;
		end else if (wr_ok) begin
			// any mismatch falls back to idle
			state_nxt = S_IDLE;
			case (state_r)
				S_IDLE: begin
					if (bus_addr == `UNLOCK_ADDR_1 && bus_wdata == `UNLOCK_DATA_1) begin
						state_nxt = S_UNLK1;
					end
				end
				S_UNLK1: begin
					if (bus_addr == `UNLOCK_ADDR_2 && bus_wdata == `UNLOCK_DATA_2) begin
						state_nxt = S_UNLK2;
					end
				end
				S_UNLK2: begin
					if (bus_addr == `UNLOCK_ADDR_1 && bus_wdata == `BYTE_PROG_DATA) begin
						state_nxt = S_PROG;
					end else if (bus_addr == `UNLOCK_ADDR_1
						&& bus_wdata == `ERASE_SETUP_DATA) begin
						state_nxt = S_ERASE3;
					end
				end
				S_PROG: begin
					state_nxt   = S_BUSY;
					prog_go_nxt = 1'b1;
				end
				S_ERASE3: begin
					if (bus_addr == `UNLOCK_ADDR_1 && bus_wdata == `UNLOCK_DATA_1) begin
						state_nxt = S_ERASE4;
					end
				end
				S_ERASE4: begin
					if (bus_addr == `UNLOCK_ADDR_2 && bus_wdata == `UNLOCK_DATA_2) begin
						state_nxt = S_ERASE5;
					end
				end
				S_ERASE5: begin
					if (bus_wdata == `SECTOR_ERASE_DATA) begin
						state_nxt    = S_BUSY;
						erase_go_nxt = 1'b1;
					end
				end
				default: state_nxt = S_IDLE;
			endcase
			if (state_nxt == S_BUSY) begin
				op_addr_nxt = bus_addr[14:0];
				op_data_nxt = bus_wdata;
				op_busy_nxt = 1'b1;
				toggle_nxt  = 1'b1;
			end
		end
		if (state_r == S_BUSY && bus_rd && flash_hit) begin
			toggle_nxt = ~toggle_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= S_IDLE;
			prog_go_r  <= 1'b0;
			erase_go_r <= 1'b0;
			op_addr_r  <= 15'h0000;
			op_data_r  <= 8'h00;
			op_busy_r  <= 1'b0;
			toggle_r   <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			prog_go_r  <= prog_go_nxt;
			erase_go_r <= erase_go_nxt;
			op_addr_r  <= op_addr_nxt;
			op_data_r  <= op_data_nxt;
			op_busy_r  <= op_busy_nxt;
			toggle_r   <= toggle_nxt;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_comb begin
		rd_valid_nxt = bus_rd;
		rd_data_nxt  = rd_data_r;
		if (bus_rd) begin
			rd_data_nxt = `UNMAPPED_READ;
			if (rom_hit) begin
				rd_data_nxt = rom_rdata;
			end else if (flash_hit && state_r == S_BUSY) begin
				rd_data_nxt = `STATUS_IDLE_BITS;
				rd_data_nxt[`STATUS_TOGGLE_BIT] = toggle_r;
			end else if (flash_hit) begin
				rd_data_nxt = arr_rdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r  <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// ---------------------------------------------------------------
	// serial mode strap
	// ---------------------------------------------------------------
	// sample only once the synchroniser holds real pin levels
	always_comb begin
		strap_cnt_nxt   = strap_cnt_r;
		serial_mode_nxt = serial_mode_r;
		if (strap_cnt_r != 2'h3) begin
			strap_cnt_nxt = strap_cnt_r + 2'h1;
		end
		// both select pins high at reset
		if (strap_cnt_r == `STRAP_SETTLE) begin
			serial_mode_nxt = &pin_sync_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r    <= 2'b00;
			pin_sync_r    <= 2'b00;
			strap_cnt_r   <= 2'h0;
			serial_mode_r <= 1'b0;
		end else begin
			pin_meta_r    <= {factory_sel_pin, loader_sel_pin};
			pin_sync_r    <= pin_meta_r;
			strap_cnt_r   <= strap_cnt_nxt;
			serial_mode_r <= serial_mode_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic       prev_stat_r;
	logic       first_pend_r;
	logic       stat_rd;
	assign stat_rd = bus_rd && flash_hit && !rom_hit && state_r == S_BUSY;
	// first_pend_r: no status read seen yet in this operation
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_stat_r  <= 1'b0;
			first_pend_r <= 1'b1;
		end else begin
			prev_stat_r  <= bus_rd ? stat_rd : prev_stat_r;
			first_pend_r <= (state_r != S_BUSY) || (first_pend_r && !stat_rd);
		end
	end

	enable_gate_a: assert property (
		command_enable_field == `CMD_FIELD_ENABLE |=> cmd_enabled_r
	) else $error("enable pattern did not open gate");

	disable_gate_a: assert property (
		command_enable_field == `CMD_FIELD_DISABLE |=> !cmd_enabled_r ##1 !prog_go_r
	) else $error("disable pattern did not close gate");

	erase_launch_a: assert property (
		wr_ok && state_r == S_ERASE5 && bus_wdata == `SECTOR_ERASE_DATA
		|=> erase_go_r && state_r == S_BUSY ##1 arr_busy
	) else $error("sector erase not launched");

	prog_launch_a: assert property (
		wr_ok && state_r == S_PROG
		|=> prog_go_r && op_data_r == $past(bus_wdata) ##1 arr_busy
	) else $error("byte program not launched");

	busy_reads_differ_a: assert property (
		stat_rd && prev_stat_r && !first_pend_r
		|=> rd_data_r[`STATUS_TOGGLE_BIT] != $past(rd_data_r[`STATUS_TOGGLE_BIT])
	) else $error("consecutive busy reads matched");

	first_toggle_a: assert property (
		stat_rd && first_pend_r |=> rd_data_r[`STATUS_TOGGLE_BIT]
	) else $error("first status read not one");

	status_read_a: assert property (
		stat_rd |=> rd_valid_r && rd_data_r[5:0] == 6'h00 && rd_data_r[7] == 1'b0
	) else $error("array data leaked while busy");

	idle_read_a: assert property (
		bus_rd && flash_hit && !rom_hit && state_r != S_BUSY
		|=> rd_data_r == $past(arr_rdata)
	) else $error("idle read not stored byte");

	rom_window_a: assert property (
		bus_rd && rom_hit |=> rd_data_r == $past(rom_rdata)
	) else $error("loader rom not mapped");

	abort_sequence_a: assert property (
		wr_ok && state_r == S_UNLK1 && bus_wdata != `UNLOCK_DATA_2
		|=> state_r == S_IDLE && !prog_go_r && !erase_go_r
	) else $error("bad write kept sequence");

	busy_ignore_a: assert property (
		state_r == S_BUSY && !prog_go_r && arr_busy && bus_wr
		|=> !prog_go_r && !erase_go_r
	) else $error("write accepted while busy");
endmodule

// ==== test/cpu_bus_model.sv ====
// cpu core model: one-cycle bus strobes, command sequences, single reads
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module cpu_bus_model (
	input  wire logic        clk,
	input  wire logic [7:0]  rd_data_r,
	input  wire logic        rd_valid_r,
	output logic      [15:0] bus_addr,
	output logic      [7:0]  bus_wdata,
	output logic             bus_wr,
	output logic             bus_rd
);
	// runs quiet
	// no fetches or interrupts, so no vector read hits busy flash
	initial begin
		bus_addr = 16'h0000;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end

	// released bus shows the inverse, never a stale copy
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		bus_addr = ~a;
		d = rd_data_r;
		v = rd_valid_r;
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		wr(`UNLOCK_ADDR_1, `UNLOCK_DATA_1);
		wr(`UNLOCK_ADDR_2, `UNLOCK_DATA_2);
		wr(`UNLOCK_ADDR_1, `BYTE_PROG_DATA);
		wr(a, d);
	endtask

	task automatic erase(input logic [15:0] a);
		wr(`UNLOCK_ADDR_1, `UNLOCK_DATA_1);
		wr(`UNLOCK_ADDR_2, `UNLOCK_DATA_2);
		wr(`UNLOCK_ADDR_1, `ERASE_SETUP_DATA);
		wr(`UNLOCK_ADDR_1, `UNLOCK_DATA_1);
		wr(`UNLOCK_ADDR_2, `UNLOCK_DATA_2);
		wr(a, `SECTOR_ERASE_DATA);
	endtask
endmodule

// ==== test/flash_cmd_sequencer_test.sv ====
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_cmd_sequencer_test;
	import flash_seq_pkg::*;
	logic        clk;
	logic        rst_n;
	logic [3:0]  command_enable_field;
	logic        factory_sel_pin;
	logic        loader_sel_pin;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  rd_data_r;
	logic        rd_valid_r;
	logic        op_busy_r;
	logic        cmd_enabled_r;
	logic        serial_mode_r;
	seq_state_t  state_r;
	int          error_cnt;
	int          n_compared;
	logic [7:0]  mem [0:32767];
	logic [7:0]  d0;
	logic [7:0]  d1;
	logic        v;
	logic [14:0] a;
	logic [14:0] b;
	logic [7:0]  x;

	flash_cmd_sequencer flash_cmd_sequencer_i (.clk(clk), .rst_n(rst_n),
		.command_enable_field(command_enable_field), .factory_sel_pin(factory_sel_pin),
		.loader_sel_pin(loader_sel_pin), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.op_busy_r(op_busy_r), .cmd_enabled_r(cmd_enabled_r),
		.serial_mode_r(serial_mode_r), .state_r(state_r));
	cpu_bus_model cpu_bus_model_i (.clk(clk), .rd_data_r(rd_data_r),
		.rd_valid_r(rd_valid_r), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic rd_chk(input logic [15:0] ad, input logic [7:0] e);
		cpu_bus_model_i.rd(ad, d0, v);
		chk("rd_valid_r", 8'h01, {7'h0, v});
		chk("rd_data_r", e, d0);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while ((op_busy_r !== 1'b0 || state_r !== S_IDLE) && n < 6000) begin
			@(negedge clk);
			n++;
		end
		if (n == 6000) begin
			error_cnt++;
			$display("wrong value op_busy_r expected 0 seen 1");
			report_and_stop();
		end
	endtask

	// first poll read shows only the toggle bit set, the next one clear
	function automatic logic [7:0] status_exp(input int n);
		return (n % 2 == 0) ? 8'h40 : 8'h00;
	endfunction

	task automatic poll(input logic [15:0] ad);
		chk("op_busy_r", 8'h01, {7'h0, op_busy_r});
		chk("state_r", {5'h0, S_BUSY}, {5'h0, state_r});
		cpu_bus_model_i.rd(ad, d0, v);
		cpu_bus_model_i.rd(ad, d1, v);
		chk("first poll", status_exp(0), d0);
		chk("second poll", status_exp(1), d1);
		wait_idle();
	endtask

	task automatic do_reset(input logic [1:0] p);
		rst_n = 1'b0;
		{factory_sel_pin, loader_sel_pin} = p;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask

	initial begin
		error_cnt = 0;
		n_compared = 0;
		command_enable_field = `CMD_FIELD_DISABLE;
		void'($urandom(77));
		for (int i = 0; i < 32768; i++) mem[i] = `ERASED_BYTE;
		do_reset(2'b00);
		// gate closed: a full program sequence does nothing
		a = 15'($urandom);
		cpu_bus_model_i.prog({1'b1, a}, 8'h00);
		chk("state_r", 8'h00, {5'h0, state_r});
		rd_chk({1'b1, a}, mem[a]);
		command_enable_field = `CMD_FIELD_ENABLE;
		@(negedge clk);
		chk("cmd_enabled_r", 8'h01, {7'h0, cmd_enabled_r});
		command_enable_field = 4'h5 + 4'($urandom % 6);
		@(negedge clk);
		chk("cmd_enabled_r", 8'h01, {7'h0, cmd_enabled_r});
		$display("test gate done");
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 15'h7FFF : 15'($urandom);
			x = 8'($urandom);
			cpu_bus_model_i.prog({1'b1, a}, x);
			poll({1'b1, a});
			mem[a] = mem[a] & x;
			rd_chk({1'b1, a}, mem[a]);
		end
		$display("test program done");
		// second sequence while busy must be dropped
		b = a ^ 15'h0100;
		cpu_bus_model_i.prog({1'b1, a ^ 15'h0001}, 8'h00);
		cpu_bus_model_i.prog({1'b1, b}, 8'h00);
		wait_idle();
		mem[a ^ 15'h0001] = 8'h00;
		rd_chk({1'b1, b}, mem[b]);
		$display("test busy done");
		for (int k = 0; k < 3; k++) begin
			if (k > 0) cpu_bus_model_i.wr(`UNLOCK_ADDR_1, `UNLOCK_DATA_1);
			if (k > 1) cpu_bus_model_i.wr(`UNLOCK_ADDR_2, `UNLOCK_DATA_2);
			cpu_bus_model_i.wr(`UNLOCK_ADDR_1, 8'h77);
			chk("state_r", 8'h00, {5'h0, state_r});
		end
		cpu_bus_model_i.wr(`UNLOCK_ADDR_1, `BYTE_PROG_DATA);
		cpu_bus_model_i.wr({1'b1, b}, 8'h00);
		chk("op_busy_r", 8'h00, {7'h0, op_busy_r});
		rd_chk({1'b1, b}, mem[b]);
		$display("test abort done");
		// erase sector 7, neighbour sector 6 keeps its byte
		b = {3'h6, 12'($urandom)};
		cpu_bus_model_i.prog({1'b1, b}, 8'h3F);
		wait_idle();
		mem[b] = mem[b] & 8'h3F;
		cpu_bus_model_i.erase({4'hF, 12'($urandom)});
		poll(16'hF555);
		for (int i = 28672; i < 32768; i++) mem[i] = `ERASED_BYTE;
		rd_chk(16'hF000, 8'hFF);
		rd_chk(16'hFFFF, 8'hFF);
		rd_chk({1'b1, b}, mem[b]);
		command_enable_field = `CMD_FIELD_DISABLE;
		@(negedge clk);
		chk("cmd_enabled_r", 8'h00, {7'h0, cmd_enabled_r});
		cpu_bus_model_i.prog(16'hF000, 8'h00);
		chk("state_r", 8'h00, {5'h0, state_r});
		rd_chk(16'hF000, 8'hFF);
		$display("test erase done");
		rd_chk(16'h7800, `UNMAPPED_READ);
		for (int p = 1; p < 4; p++) begin
			do_reset(2'(p));
			chk("serial_mode_r", (p == 3) ? 8'h01 : 8'h00, {7'h0, serial_mode_r});
		end
		for (int k = 0; k < 7; k++) begin
			rd_chk(16'h7800 + 16'(k), 8'(k));
		end
		rd_chk(16'h7FFF, 8'hFF);
		rd_chk(16'h77FF, `UNMAPPED_READ);
		rd_chk({1'b1, b}, mem[b]);
		$display("test serial done");
		report_and_stop();
	end
endmodule
